//--- core/tcm_pkg.sv
/*
  constants, field layouts and types of the led matrix dimming block.
  assumes a 50 MHz system clock and a 32-bit word register port.
*/
`default_nettype none

package tcm_pkg;

  // register byte offsets
  localparam logic [7:0] CFG_OFS    = 8'h00;
  localparam logic [7:0] ORDER_OFS  = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] DOT_BASE   = 8'h10;
  localparam logic [7:0] DOT_SPAN   = 8'h40;
  localparam int         DOT_NUM    = 16;
  localparam logic [3:0] DIRECT_IDX = 4'hC;

  // reset values
  localparam logic [15:0] CFG_RST   = 16'h0000;
  localparam logic [7:0]  ORDER_RST = 8'hE4;
  localparam logic [7:0]  LEVEL_RST = 8'h80;

  // drive mode codes
  localparam logic [2:0] MODE_DIRECT = 3'h0;
  localparam logic [2:0] MODE_TCM4   = 3'h4;

  // pulse alignment codes
  localparam logic [1:0] ALIGN_FWD  = 2'h0;
  localparam logic [1:0] ALIGN_MID  = 2'h1;
  localparam logic [1:0] ALIGN_BACK = 2'h2;

  // time base
  localparam int          CLK_KHZ = 50000;
  localparam int          OSC_KHZ = 6000;
  localparam logic [5:0]  ACC_MOD = 6'(CLK_KHZ / 1000);
  localparam logic [5:0]  ACC_INC = 6'(OSC_KHZ / 1000);
  localparam logic [7:0]  PWM_TOP = 8'hFE;
  localparam logic [7:0]  PWM_MAX = 8'hFF;

  // blank interval
  localparam int CLK_NS         = 20;
  localparam int BLANK_SHORT_NS = 1000;
  localparam int BLANK_LONG_NS  = 2000;
  localparam logic [6:0] BLANK_SHORT_CYC =
    7'((BLANK_SHORT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [6:0] BLANK_LONG_CYC =
    7'((BLANK_LONG_NS + CLK_NS - 1) / CLK_NS);

  // configuration word, low 16 bits of CFG_OFS
  typedef struct packed {
    logic [3:0] mix_mask;
    logic       rsvd;
    logic       global_range;
    logic [1:0] clamp_level;
    logic       clamp_sel;
    logic       clamp_dis;
    logic       blank_long;
    logic       sync_out_en;
    logic       pwm_12k;
    logic [2:0] mode;
  } tcm_cfg_t;

  // per dot word, low 19 bits of each dot register
  typedef struct packed {
    logic       exp_en;
    logic [1:0] align;
    logic [7:0] dot_level;
    logic [7:0] duty;
  } tcm_dot_t;

  localparam tcm_dot_t DOT_RST = '{1'b0, ALIGN_FWD, LEVEL_RST, 8'h00};

  // cubic curve: monotonic, 0 maps to 0 and 255 to 255
  function automatic logic [2047:0] tcm_exp_table();
    logic [2047:0] t;
    int            v;
    t = '0;
    for (int i = 0; i < 256; i++) begin
      v = (i * i * i) / (255 * 255);
      t[i*8 +: 8] = 8'(v);
    end
    return t;
  endfunction

  localparam logic [2047:0] EXP_LUT = tcm_exp_table();

endpackage

`default_nettype wire

//--- core/tcm_led_dim.sv
/*
  scan sequencer, pwm dimming and current scaling for four channel pins
  of a time cross multiplexed led matrix, with a small register file.
  assumes a 50 MHz clock, a synchronous active high reset, a register
  master that never strobes read and write together, and an analog
  driver stage that acts on the per pin switch, sink and clamp levels.
*/
// Implementation choices: the register addresses and strobed register access.
// Functional notes
// - mode field 0 is direct drive, 1 to 4 multiplex with that many slots.
// - modes 5 to 7 mix drive with 1 to 3 slots; mix_mask pins direct.
// - scan order resets to ascending pins 0,1,2,3.
// - multiplex drives up to 12 dots over 1 to 4 slots.
// - dot k of an anode has its cathode at (anode+k+1) mod 4.
// - one pin is scan switch per sub-period, others sink.
// - sub-period is one full pwm cycle then a blank interval.
// - blank interval is 1 us or 2 us by a select bit.
// - clamp on after reset; disable bit set turns it off.
// - clamp during pwm off time plus blank, or blank only.
// - 2-bit clamp level shared by switch and sinks.
// - global range bit picks full scale, reset low.
// - per dot 8-bit current scale resets to 80h.
// - 8-bit pwm at 24 kHz or 12 kHz by one bit.
// - pwm time base comes from a 6 MHz oscillator.
// - sync direction bit drives or takes the shared pwm clock.
// - per dot 2-bit field picks forward, middle or backward.
// - forward pulse starts at period start.
// - middle pulse is centred in the period.
// - backward pulse ends at period end.
// - per dot bit picks linear or exponential duty mapping.
`timescale 1ns/1ps
`default_nettype none

module tcm_led_dim (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // shared pwm clock pin
  input  wire logic        sync_in,
  output logic             sync_out,
  output logic             sync_oe,
  // channel pin drive
  output logic      [3:0]  scan_sw,
  output logic      [3:0]  sink_en,
  output logic      [31:0] sink_scale,
  output logic      [3:0]  clamp_en,
  output logic      [1:0]  clamp_level,
  output logic             global_range
);

  typedef enum logic {ST_DIM, ST_BLANK} tcm_state_t;

  tcm_pkg::tcm_cfg_t cfg_reg;
  tcm_pkg::tcm_dot_t dot_reg [tcm_pkg::DOT_NUM];
  logic [7:0]        order_reg;

  tcm_state_t  state_reg;
  logic [7:0]  pwm_cnt_reg;
  logic [6:0]  blank_cnt_reg;
  logic [1:0]  slot_reg;
  logic [5:0]  acc_reg;
  logic        int_tick_reg;
  logic [2:0]  sync_ff_reg;
  logic        sync_lvl_reg;
  logic        ext_tick_reg;
  logic        half_reg;

  logic        tick;
  logic        adv;
  logic [2:0]  nscan;
  logic        scanning;
  logic [1:0]  anode;
  logic [6:0]  blank_len;
  logic [7:0]  dot_off;
  logic        dot_hit;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  // register writes
  assign dot_off = reg_addr - tcm_pkg::DOT_BASE;
  assign dot_hit = (reg_addr >= tcm_pkg::DOT_BASE) &&
                   (dot_off < tcm_pkg::DOT_SPAN) &&
                   (reg_addr[1:0] == 2'b00);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cfg_reg   <= tcm_pkg::tcm_cfg_t'(tcm_pkg::CFG_RST);
      order_reg <= tcm_pkg::ORDER_RST;
    end else if (reg_wr) begin
      if (reg_addr == tcm_pkg::CFG_OFS) begin
        cfg_reg <= tcm_pkg::tcm_cfg_t'(reg_wdata[15:0]);
      end
      if (reg_addr == tcm_pkg::ORDER_OFS) begin
        order_reg <= reg_wdata[7:0];
      end
    end
  end

  genvar gd;
  generate
    for (gd = 0; gd < tcm_pkg::DOT_NUM; gd++) begin : g_dot
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          dot_reg[gd] <= tcm_pkg::DOT_RST;
        end else if (reg_wr && dot_hit && dot_off[5:2] == 4'(gd)) begin
          dot_reg[gd] <= tcm_pkg::tcm_dot_t'(reg_wdata[18:0]);
        end
      end
    end
  endgenerate

  a_reset_vals: assert property (
    $past(sys_rst) |-> order_reg == tcm_pkg::ORDER_RST &&
      !global_range && dot_reg[0].dot_level == tcm_pkg::LEVEL_RST &&
      !cfg_reg.clamp_dis)
    else $error("register reset values wrong");

  // register reads, data one cycle after the strobe
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      if (reg_addr == tcm_pkg::CFG_OFS) begin
        reg_rdata <= {16'h0000, cfg_reg};
      end else if (reg_addr == tcm_pkg::ORDER_OFS) begin
        reg_rdata <= {24'h00_0000, order_reg};
      end else if (reg_addr == tcm_pkg::STATUS_OFS) begin
        reg_rdata <= {19'h0, anode, slot_reg,
                      state_reg == ST_BLANK, pwm_cnt_reg};
      end else if (dot_hit) begin
        reg_rdata <= {13'h0, dot_reg[dot_off[5:2]]};
      end else begin
        reg_rdata <= '0;
      end
    end else begin
      reg_rdata <= '0;
    end
  end

  // internal 6 MHz time base by a fractional accumulator
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      acc_reg      <= '0;
      int_tick_reg <= 1'b0;
    end else if (acc_reg + tcm_pkg::ACC_INC >= tcm_pkg::ACC_MOD) begin
      acc_reg      <= acc_reg + tcm_pkg::ACC_INC - tcm_pkg::ACC_MOD;
      int_tick_reg <= 1'b1;
    end else begin
      acc_reg      <= acc_reg + tcm_pkg::ACC_INC;
      int_tick_reg <= 1'b0;
    end
  end

  sequence seq_tick_gap;
    !int_tick_reg [*7];
  endsequence

  a_tick_rate: assert property (
    int_tick_reg |=> seq_tick_gap ##[1:2] int_tick_reg)
    else $error("oscillator tick spacing wrong");

  // shared clock pin: each filtered edge in counts as one tick
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sync_ff_reg  <= '0;
      sync_lvl_reg <= 1'b0;
      ext_tick_reg <= 1'b0;
    end else begin
      sync_ff_reg <= {sync_ff_reg[1:0], sync_in};
      if (sync_ff_reg[1] == sync_ff_reg[2]) begin
        sync_lvl_reg <= sync_ff_reg[2];
      end
      ext_tick_reg <= (sync_ff_reg[1] == sync_ff_reg[2]) &&
                      (sync_ff_reg[2] != sync_lvl_reg);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sync_out <= 1'b0;
      sync_oe  <= 1'b0;
    end else begin
      sync_oe <= cfg_reg.sync_out_en;
      if (int_tick_reg) begin
        sync_out <= ~sync_out;
      end
    end
  end

  assign tick = cfg_reg.sync_out_en ? int_tick_reg : ext_tick_reg;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      half_reg <= 1'b0;
    end else if (tick) begin
      half_reg <= ~half_reg;
    end
  end

  // the slow rate steps the counter on every second tick
  assign adv = tick && (!cfg_reg.pwm_12k || half_reg);

  // scan slot count from the mode field
  always_comb begin
    if (cfg_reg.mode > tcm_pkg::MODE_TCM4) begin
      nscan = cfg_reg.mode - tcm_pkg::MODE_TCM4;
    end else begin
      nscan = cfg_reg.mode;
    end
  end

  assign scanning  = nscan != 3'h0;
  assign anode     = order_reg[slot_reg*2 +: 2];
  assign blank_len = cfg_reg.blank_long ? tcm_pkg::BLANK_LONG_CYC
                                        : tcm_pkg::BLANK_SHORT_CYC;

  // sub-period sequencer: one pwm cycle, then a blank interval
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg     <= ST_DIM;
      pwm_cnt_reg   <= '0;
      blank_cnt_reg <= '0;
      slot_reg      <= '0;
    end else begin
      case (state_reg)
        ST_DIM: begin
          if (adv && pwm_cnt_reg == tcm_pkg::PWM_TOP) begin
            state_reg     <= ST_BLANK;
            pwm_cnt_reg   <= '0;
            blank_cnt_reg <= '0;
          end else if (adv) begin
            pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
          end
        end
        ST_BLANK: begin
          blank_cnt_reg <= blank_cnt_reg + 7'h01;
          if (blank_cnt_reg == blank_len - 7'h01) begin
            state_reg <= ST_DIM;
            if ({1'b0, slot_reg} + 3'h1 >= nscan) begin
              slot_reg <= '0;
            end else begin
              slot_reg <= slot_reg + 2'h1;
            end
          end
        end
        default: begin
          state_reg <= ST_DIM;
        end
      endcase
    end
  end

  a_pwm_wrap: assert property (
    (state_reg == ST_DIM && adv && pwm_cnt_reg == tcm_pkg::PWM_TOP)
      |=> state_reg == ST_BLANK && pwm_cnt_reg == 8'h00)
    else $error("pwm counter did not wrap into blank");

  a_dim_length: assert property (
    (state_reg == ST_BLANK && $past(state_reg) == ST_DIM) |->
      $past(pwm_cnt_reg) == tcm_pkg::PWM_TOP && $past(adv))
    else $error("dimming interval ended early");

  a_blank_length: assert property (
    (state_reg == ST_DIM && $past(state_reg) == ST_BLANK) |->
      $past(blank_cnt_reg) == $past(blank_len) - 7'h01)
    else $error("blank interval length wrong");

  a_slot_wrap: assert property (
    (state_reg == ST_DIM && $past(state_reg) == ST_BLANK &&
     $past(nscan) == 3'h1) |-> slot_reg == 2'h0)
    else $error("single slot mode left slot zero");

  // per pin drive
  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++) begin : g_pin
      logic              is_scan;
      logic              direct;
      logic [1:0]        k;
      logic [3:0]        idx;
      logic              valid;
      tcm_pkg::tcm_dot_t dot;
      logic [7:0]        d;
      logic [8:0]        start;
      logic              pulse;
      logic              sink_on;

      assign is_scan = scanning && anode == 2'(gp) &&
                       state_reg == ST_DIM;
      assign direct  = cfg_reg.mode == tcm_pkg::MODE_DIRECT ||
                       (cfg_reg.mode > tcm_pkg::MODE_TCM4 &&
                        cfg_reg.mix_mask[gp]);
      assign k       = 2'(gp) - anode - 2'h1;
      assign idx     = direct ? tcm_pkg::DIRECT_IDX + 4'(gp)
                              : 4'(anode * 3) + {2'b00, k};
      assign valid   = direct || (scanning && k != 2'h3);
      assign dot     = dot_reg[idx];
      assign d       = dot.exp_en ? tcm_pkg::EXP_LUT[dot.duty*8 +: 8]
                                  : dot.duty;
      assign start   = {1'b0, tcm_pkg::PWM_MAX - d} >> 1;

      always_comb begin
        case (dot.align)
          tcm_pkg::ALIGN_MID: begin
            pulse = {1'b0, pwm_cnt_reg} >= start &&
                    {1'b0, pwm_cnt_reg} < start + {1'b0, d};
          end
          tcm_pkg::ALIGN_BACK: begin
            pulse = pwm_cnt_reg >= tcm_pkg::PWM_MAX - d;
          end
          default: begin
            pulse = pwm_cnt_reg < d;
          end
        endcase
      end

      assign sink_on = state_reg == ST_DIM && valid && !is_scan &&
                       pulse;

      always_ff @(posedge clock) begin
        if (sys_rst) begin
          scan_sw[gp]          <= 1'b0;
          sink_en[gp]          <= 1'b0;
          sink_scale[gp*8 +: 8] <= '0;
          clamp_en[gp]         <= 1'b0;
        end else begin
          scan_sw[gp]          <= is_scan;
          sink_en[gp]          <= sink_on;
          sink_scale[gp*8 +: 8] <= valid ? dot.dot_level : 8'h00;
          clamp_en[gp]         <= !cfg_reg.clamp_dis && !is_scan &&
                                  !sink_on && (state_reg == ST_BLANK ||
                                  cfg_reg.clamp_sel);
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      clamp_level  <= '0;
      global_range <= 1'b0;
    end else begin
      clamp_level  <= cfg_reg.clamp_level;
      global_range <= cfg_reg.global_range;
    end
  end

  a_one_switch: assert property (
    $onehot0(scan_sw) && (scan_sw & sink_en) == 4'h0)
    else $error("more than one scan switch or switch also sinking");

  a_switch_in_dim: assert property (
    (scan_sw != 4'h0) |-> $past(state_reg) == ST_DIM &&
      $past(scanning))
    else $error("scan switch on outside dimming");

  a_direct_no_scan: assert property (
    $past(cfg_reg.mode) == tcm_pkg::MODE_DIRECT |-> scan_sw == 4'h0)
    else $error("scan switch active in direct drive");

  a_clamp_off: assert property (
    $past(cfg_reg.clamp_dis) |-> clamp_en == 4'h0)
    else $error("clamp active while disabled");

  a_clamp_window: assert property (
    $past(!cfg_reg.clamp_sel && state_reg == ST_DIM) |->
      clamp_en == 4'h0)
    else $error("clamp outside blank with blank-only window");

  sequence seq_fwd_dot0;
    cfg_reg.mode == tcm_pkg::MODE_DIRECT && state_reg == ST_DIM &&
      dot_reg[tcm_pkg::DIRECT_IDX].align == tcm_pkg::ALIGN_FWD &&
      !dot_reg[tcm_pkg::DIRECT_IDX].exp_en &&
      dot_reg[tcm_pkg::DIRECT_IDX].duty != 8'h00;
  endsequence

  a_fwd_start: assert property (
    (seq_fwd_dot0 and pwm_cnt_reg == 8'h00) |=> sink_en[0])
    else $error("forward pulse missing at period start");

  a_back_end: assert property (
    (cfg_reg.mode == tcm_pkg::MODE_DIRECT && state_reg == ST_DIM &&
     dot_reg[tcm_pkg::DIRECT_IDX].align == tcm_pkg::ALIGN_BACK &&
     !dot_reg[tcm_pkg::DIRECT_IDX].exp_en &&
     dot_reg[tcm_pkg::DIRECT_IDX].duty != 8'h00 &&
     pwm_cnt_reg == tcm_pkg::PWM_TOP) |=> sink_en[0])
    else $error("backward pulse missing at period end");

endmodule

`default_nettype wire

//--- test/tcm_matrix_model.sv
/*
  led matrix hung on the four channel pins: reports lit dots and misuse.
  assumes the pin outputs of the dimming block and a known direct mask.
*/
`timescale 1ns/1ps
`default_nettype none

module tcm_matrix_model (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // pin drive seen
  input  wire logic [3:0]  scan_sw,
  input  wire logic [3:0]  sink_en,
  input  wire logic [3:0]  clamp_en,
  input  wire logic [3:0]  direct_mask,
  // observations
  output logic      [15:0] lit,
  output logic             fault_seen
);
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      lit[i] = scan_sw[i/3] & sink_en[(i/3+i%3+1)%4]
               & ~direct_mask[(i/3+i%3+1)%4];
    end
    for (int p = 0; p < 4; p++) begin
      lit[12+p] = sink_en[p] & direct_mask[p];
    end
  end

  // two switches at once short the supply through a dot
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fault_seen <= 1'b0;
    end else if ($countones(scan_sw) > 1 || |(scan_sw & sink_en)
                 || |(clamp_en & (scan_sw | sink_en))) begin
      fault_seen <= 1'b1;
    end
  end
endmodule

`default_nettype wire

//--- test/tcm_led_dim_tb.sv
/*
  self-checking bench of the led matrix dimming block: register tasks
  and per slot pin timing measured against the expected pwm shapes.
  assumes the matrix model beside the block and a 50 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none

module tcm_led_dim_tb;
  localparam int     LIMIT = 80000;
  logic              clock = 1'b0;
  logic              sys_rst = 1'b1;
  logic [7:0]        reg_addr = '0;
  logic [31:0]       reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic              sync_in = 1'b0;
  logic              ext_on = 1'b0;
  logic [3:0]        direct_mask = '0;
  logic [31:0]       reg_rdata, sink_scale;
  logic              sync_out, sync_oe, global_range, fault_seen, sv;
  logic [3:0]        scan_sw, sink_en, clamp_en, cmid, cblank;
  logic [1:0]        clamp_level;
  logic [15:0]       lit;
  logic [7:0]        lvl;
  int                error_cnt = 0;
  int                samples_checked = 0;
  int                cyc = 0;
  int                ext_div = 0;
  int                dim, on, first, last, blank, n, s;
  tcm_pkg::tcm_cfg_t cfg;

  always #10 clock = ~clock;

  // outside pwm clock source: one edge every 10 cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (ext_on) begin
      ext_div <= (ext_div == 9) ? 0 : ext_div + 1;
      if (ext_div == 9) sync_in <= ~sync_in;
    end
    if (cyc == LIMIT) begin
      error_cnt++;
      report_and_stop();
    end
  end

  tcm_led_dim i_dut (
    .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sync_in(sync_in), .sync_out(sync_out),
    .sync_oe(sync_oe), .scan_sw(scan_sw), .sink_en(sink_en),
    .sink_scale(sink_scale), .clamp_en(clamp_en),
    .clamp_level(clamp_level), .global_range(global_range));

  tcm_matrix_model i_matrix (
    .clock(clock), .sys_rst(sys_rst), .scan_sw(scan_sw),
    .sink_en(sink_en), .clamp_en(clamp_en), .direct_mask(direct_mask),
    .lit(lit), .fault_seen(fault_seen));

  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic near(string name, int seen, int exp, int tol);
    samples_checked++;
    if (seen < exp - tol || seen > exp + tol) begin
      error_cnt++;
      $display("[FAIL] %s expected %0d seen %0d", name, exp, seen);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] exp, string name);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd   <= 1'b0;
    @(negedge clock);
    check(name, reg_rdata, exp);
  endtask

  function automatic logic [7:0] dotad(int i);
    return 8'(tcm_pkg::DOT_BASE + 4 * i);
  endfunction

  task automatic dot(int i, logic ex, logic [1:0] al, logic [15:0] lv_du);
    wr(dotad(i), {13'h0, ex, al, lv_du});
  endtask

  // one slot of switch sw: length, pulse of dot d, then the blank after
  task automatic meas(logic [3:0] sw, int d, bit fresh);
    int c;
    c = (d < 12) ? (d / 3 + d % 3 + 1) % 4 : d - 12;
    dim = 0; on = 0; first = -1; last = -1; blank = 0; n = 0;
    lvl = 'x;
    while (fresh && scan_sw !== 4'h0 && n < 20000) begin
      @(negedge clock);
      n++;
    end
    while (scan_sw !== sw && n < 20000) begin
      @(negedge clock);
      n++;
    end
    while (scan_sw === sw && dim < 9000) begin
      if (lit[d]) begin
        if (first < 0) first = dim;
        last = dim;
        on++;
        lvl = sink_scale[c*8 +: 8];
      end
      if (dim == 1000) cmid = clamp_en;
      dim++;
      @(negedge clock);
    end
    while (scan_sw === 4'h0 && blank < 300) begin
      if (blank == 20) cblank = clamp_en;
      blank++;
      @(negedge clock);
    end
  endtask

  initial begin
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    @(negedge clock);
    check("range reset", global_range, 1'b0);
    rd(tcm_pkg::CFG_OFS, 32'h0000_0000, "cfg reset");
    rd(tcm_pkg::ORDER_OFS, 32'h0000_00E4, "order reset");
    for (int i = 0; i < 16; i++) begin
      rd(dotad(i), 32'h0000_8000, "dot reset");
    end
    rd(8'h0C, 32'h0000_0000, "unmapped");
    rd(8'h11, 32'h0000_0000, "unaligned");
    // four slots, one pulse shape per slot
    cfg = '0;
    cfg.mode = tcm_pkg::MODE_TCM4;
    cfg.sync_out_en = 1'b1;
    cfg.clamp_sel = 1'b1;
    cfg.clamp_level = 2'h2;
    cfg.global_range = 1'b1;
    wr(tcm_pkg::CFG_OFS, {16'h0000, cfg});
    dot(0, 1'b0, tcm_pkg::ALIGN_FWD, 16'h1140);
    dot(3, 1'b0, tcm_pkg::ALIGN_MID, 16'h2240);
    dot(6, 1'b0, tcm_pkg::ALIGN_BACK, 16'h3340);
    dot(9, 1'b1, tcm_pkg::ALIGN_FWD, 16'h4480);
    rd(dotad(9), 32'h0004_4480, "dot rw");
    check("range", global_range, 1'b1);
    check("clamp level", clamp_level, 2'h2);
    check("sync drive", sync_oe, 1'b1);
    n = 0;
    sv = sync_out;
    repeat (600) begin
      @(negedge clock);
      if (sync_out !== sv) n++;
      sv = sync_out;
    end
    near("osc toggles", n, 72, 2);
    meas(4'b0001, 0, 1'b1);
    near("fwd on", on, 533, 12);
    near("fwd start", first, 0, 3);
    near("dim len", dim, 2125, 10);
    near("blank", blank, 50, 2);
    check("dot level", lvl, 8'h11);
    check("clamp dim", cmid, 4'b1110);
    check("clamp blank", cblank, 4'hF);
    check("next slot", scan_sw, 4'b0010);
    meas(4'b0010, 3, 1'b0);
    near("mid on", on, 533, 12);
    near("mid centre", first, dim - 1 - last, 10);
    meas(4'b0100, 6, 1'b0);
    near("back end", last, dim - 1, 3);
    meas(4'b1000, 9, 1'b0);
    near("exp on", on, 267, 12);
    check("wrap", scan_sw, 4'b0001);
    // one slot, long period and blank, clamp off
    cfg.mode = 3'h1;
    cfg.pwm_12k = 1'b1;
    cfg.blank_long = 1'b1;
    cfg.clamp_dis = 1'b1;
    cfg.clamp_sel = 1'b0;
    wr(tcm_pkg::CFG_OFS, {16'h0000, cfg});
    meas(4'b0001, 0, 1'b1);
    near("dim 12k", dim, 4250, 20);
    near("blank long", blank, 100, 2);
    check("clamp off", cblank, 4'h0);
    check("one slot", scan_sw, 4'b0001);
    // two slots in reverse order on an outside pwm clock
    cfg = '0;
    cfg.mode = 3'h2;
    wr(tcm_pkg::CFG_OFS, {16'h0000, cfg});
    wr(tcm_pkg::ORDER_OFS, 32'h0000_001B);
    dot(11, 1'b0, tcm_pkg::ALIGN_FWD, 16'h80FF);
    ext_on <= 1'b1;
    @(negedge clock);
    check("sync input", sync_oe, 1'b0);
    meas(4'b1000, 11, 1'b1);
    near("ext dim", dim, 2550, 20);
    near("full on", on, dim, 3);
    check("clamp blank only", cmid, 4'h0);
    check("order", scan_sw, 4'b0100);
    ext_on <= 1'b0;
    // direct drive: no switch ever, sinks pulse alone
    cfg = '0;
    cfg.sync_out_en = 1'b1;
    wr(tcm_pkg::CFG_OFS, {16'h0000, cfg});
    direct_mask <= 4'hF;
    dot(12, 1'b0, tcm_pkg::ALIGN_FWD, 16'h80FF);
    n = 0;
    s = 0;
    repeat (3000) begin
      @(negedge clock);
      if (lit[12] === 1'b1) n++;
      if (scan_sw !== 4'h0) s++;
    end
    near("direct scan", s, 0, 0);
    near("direct on", n, 2950, 55);
    // one whole sub-period window sees one backward pulse's worth of on time
    dot(12, 1'b0, tcm_pkg::ALIGN_BACK, 16'h8040);
    n = 0;
    repeat (2175) begin
      @(negedge clock);
      if (lit[12] === 1'b1) n++;
    end
    near("direct back", n, 533, 12);
    // mixed drive: pin 3 direct beside one scan slot
    cfg.mode = 3'h5;
    wr(tcm_pkg::CFG_OFS, {16'h0000, cfg});
    wr(tcm_pkg::ORDER_OFS, 32'h0000_00E4);
    cfg.mix_mask = 4'h8;
    wr(tcm_pkg::CFG_OFS, {16'h0000, cfg});
    direct_mask <= 4'h8;
    dot(15, 1'b0, tcm_pkg::ALIGN_FWD, 16'h80FF);
    meas(4'b0001, 15, 1'b1);
    near("mix direct", on, dim, 3);
    check("mix slot", scan_sw, 4'b0001);
    check("matrix misuse", fault_seen, 1'b0);
    report_and_stop();
  end
endmodule

`default_nettype wire
